// File: core/crth_top.sv
// Ramp counter controller: auto-zero, peak, channel, alarms
`timescale 1ns/1ps
`default_nettype none
module crth_top import crth_pkg::*; #(
    parameter int HALF_CYCLES = HALF_CYC,
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int CHAN_STEPS  = CHAN_TYP
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Analogue side pins
    input  wire logic        cmp_above,
    input  wire logic        warn_in,
    input  wire logic        full_in,
    input  wire logic        zero_err_in,
    output logic      [7:0]  dac_code,
    output logic      [7:0]  chan_out,
    // Alarms and interrupt
    output logic             warn_out,
    output logic             full_out,
    output logic             flash_zero,
    output logic             irq
);

    if (CHAN_STEPS < 2 || CHAN_STEPS > CODES) begin : g_chk
        $error("CHAN_STEPS out of range");
    end
    if (HALF_CYCLES < 1 || CONV_CYCLES < 2) begin : g_chk2
        $error("Timing parameter too small");
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: accept a change once stages 2 and 3 agree
    logic [3:0] s1, s2, s3, pf;
    crth_pins_s pin;
    wire  [3:0] raw   = {zero_err_in, full_in, warn_in, cmp_above};
    wire  [3:0] agree = ~(s2 ^ s3);
    assign pin = crth_pins_s'(pf);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            s3 <= 4'h0;
            pf <= 4'h0;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            pf <= (s3 & agree) | (pf & ~agree); // RL16
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    crth_ctrl_s      ctrl;
    logic [NEV-1:0]  stat, mask;
    logic [7:0]      steps_m1;
    logic [31:0]     pre, conv_per;
    logic            wr_pend;
    logic [7:0]      wr_addr;

    wire       take   = hsel && hready && htrans[1];
    wire [7:0] a_addr = {haddr[7:2], 2'b00};
    wire       w_ctrl = wr_pend && wr_addr == A_CTRL;
    wire       w_stat = wr_pend && wr_addr == A_STAT;
    wire       w_mask = wr_pend && wr_addr == A_MASK;
    wire       w_stps = wr_pend && wr_addr == A_STEPS;
    wire       w_pre  = wr_pend && wr_addr == A_PRE;
    wire       w_conv = wr_pend && wr_addr == A_CONV;
    wire [NEV-1:0] w1c = w_stat ? hwdata[NEV-1:0] : '0;
    logic [NEV-1:0] ev;

    // Read mux; unmapped words read zero
    logic [7:0]  count, chan;
    logic [31:0] rd_mux;
    always_comb begin
        unique case (a_addr)
            A_CTRL:  rd_mux = {27'h0, ctrl};
            A_STAT:  rd_mux = {28'h0, stat};
            A_MASK:  rd_mux = {28'h0, mask};
            A_COUNT: rd_mux = {24'h0, count};
            A_CHAN:  rd_mux = {24'h0, chan};
            A_STEPS: rd_mux = {24'h0, steps_m1};
            A_PRE:   rd_mux = pre;
            A_CONV:  rd_mux = conv_per;
            A_PINS:  rd_mux = {28'h0, pf};
            default: rd_mux = 32'h0;
        endcase
    end

    // Bus phases: zero wait states, always OKAY
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend <= take && hwrite;
            wr_addr <= a_addr;
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Clear bit is a one-cycle pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl     <= crth_ctrl_s'(CTRL_RST);
            mask     <= '0;
            steps_m1 <= 8'(CHAN_STEPS - 1);
            pre      <= 32'(HALF_CYCLES - 1);
            conv_per <= 32'(CONV_CYCLES - 1);
        end else begin
            ctrl.clr <= 1'b0;
            if (w_ctrl) begin
                ctrl <= crth_ctrl_s'(hwdata[CTRL_W-1:0]);
            end
            if (w_mask) mask <= hwdata[NEV-1:0];
            if (w_stps) steps_m1 <= hwdata[7:0]; // RL10
            if (w_pre)  pre <= hwdata;            // RL17
            if (w_conv) conv_per <= hwdata;
        end
    end

    // Sticky status, new event beats same-cycle clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stat <= '0;
            irq  <= 1'b0;
        end else begin
            stat <= (stat & ~w1c) | ev;
            irq  <= |(stat & mask);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Prescaler and conversion oscillator, free running
    logic [31:0] pre_cnt, conv_cnt;
    logic        sq;
    wire half_tick = pre_cnt >= pre;
    wire conv_tick = conv_cnt >= conv_per;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_cnt  <= 32'h0;
            conv_cnt <= 32'h0;
            sq       <= 1'b0;
        end else begin
            pre_cnt  <= half_tick ? 32'h0 : pre_cnt + 32'h1; // RL17
            conv_cnt <= conv_tick ? 32'h0 : conv_cnt + 32'h1; // RL8
            if (half_tick) sq <= ~sq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Ramp counter with synchronous count enable
    crth_cst_e cst, next_cst;
    logic      stopped, cmp_d;
    logic [7:0] next_count;
    logic       count_en;

    wire is_az   = ctrl.mode == M_AZ;
    wire is_peak = ctrl.mode == M_PEAK;
    wire is_chan = ctrl.mode == M_CHAN;
    wire at_top  = count == steps_m1;
    wire clear_cnt = !ctrl.run || ctrl.clr            // RL15 RL5
                   || (is_az && !ctrl.az_en)          // RL4
                   || (is_chan && conv_tick);         // RL8
    // Settle window after each clear: the comparator still reports the
    // old code through the DAC and the pin synchroniser, so a stale low
    // would end a conversion or stop auto-zero at code zero
    logic [3:0] settle;
    wire        cmp_ok = settle == 4'h0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settle <= 4'(SETTLE_CYC);
        end else if (clear_cnt) begin
            settle <= 4'(SETTLE_CYC);
        end else if (!cmp_ok) begin
            settle <= settle - 4'h1;
        end
    end

    wire go      = count_en && !clear_cnt;
    wire done    = is_chan && cst == C_CONV && !conv_tick
                   && ((cmp_ok && !pin.cmp) || at_top); // RL9 RL10

    always_comb begin
        unique case (ctrl.mode)
            M_AZ:   count_en = ctrl.az_en && !stopped
                               && cmp_ok && pin.cmp;      // RL3
            M_PEAK: count_en = cmp_ok && pin.cmp;         // RL6 RL7
            M_CHAN: count_en = cst == C_CONV && cmp_ok
                               && pin.cmp && !at_top;
            M_RAMP: count_en = 1'b1;
        endcase
    end

    // Plain add wraps FF to 00
    assign next_count = clear_cnt ? 8'h00 :
                        go ? count + 8'h01 : count; // RL1 RL2 RL14

    always_comb begin
        unique case (cst)
            C_IDLE: next_cst = (is_chan && conv_tick) ? C_CONV : C_IDLE;
            C_CONV: next_cst = (done || !is_chan) ? C_IDLE : C_CONV;
        endcase
    end

    assign ev[EV_AZ]   = is_az && ctrl.az_en && !stopped
                         && cmp_ok && !pin.cmp && ctrl.run;
    assign ev[EV_PEAK] = is_peak && cmp_d && !pin.cmp;
    assign ev[EV_DONE] = done;
    assign ev[EV_WRAP] = go && count == CODE_MAX;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count   <= 8'h00;
            cst     <= C_IDLE;
            stopped <= 1'b0;
            cmp_d   <= 1'b0;
            chan    <= 8'h00;
        end else begin
            count <= next_count;
            cst   <= next_cst;
            cmp_d <= pin.cmp;
            if (!is_az || !ctrl.az_en) stopped <= 1'b0; // RL4
            else if (ev[EV_AZ]) stopped <= 1'b1;         // RL3
            if (done) chan <= count;                     // RL9
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dac_code   <= 8'h00;
            chan_out   <= 8'h00;
            warn_out   <= 1'b0;
            full_out   <= 1'b0;
            flash_zero <= 1'b0;
        end else begin
            dac_code   <= next_count;
            chan_out   <= done ? count : chan;
            warn_out   <= pin.warn && sq; // RL11
            full_out   <= pin.full;       // RL12
            flash_zero <= pin.zerr && sq; // RL13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_run_clears: assert property (!ctrl.run |=> count == 8'h00) // RL15
        else $error("count not cleared while run low");
    a_count_step: assert property (go && count != CODE_MAX
        |=> count == $past(count) + 8'h01) // RL1
        else $error("gated count did not advance by one");
    a_wrap_zero: assert property (go && count == CODE_MAX
        |=> count == 8'h00 && stat[EV_WRAP]) // RL14
        else $error("full counter did not wrap");
    a_az_stop: assert property (ev[EV_AZ] |=> stopped ##1 $stable(count)) // RL3
        else $error("auto-zero did not stop");
    a_az_hold: assert property (is_az && ctrl.az_en && stopped && ctrl.run
        && !ctrl.clr |=> $stable(count)) // RL4
        else $error("auto-zero code moved");
    a_az_off: assert property (is_az && !ctrl.az_en |=> count == 8'h00) // RL4
        else $error("auto-zero off did not clear");
    a_peak_hold: assert property (is_peak && !pin.cmp && !clear_cnt
        |=> $stable(count)) // RL6
        else $error("peak code changed while below");
    a_peak_clear: assert property (is_peak && ctrl.clr |=> count == 8'h00) // RL5
        else $error("reset pulse did not clear");
    a_chan_steady: assert property (!done |=> $stable(chan)) // RL9
        else $error("channel latch moved");
    a_chan_limit: assert property (is_chan && !clear_cnt
        |-> count <= steps_m1 || !go) // RL10
        else $error("channel count past limit");
    a_full_alarm: assert property (pin.full |=> full_out) // RL12
        else $error("full alarm not asserted");
    a_warn_off: assert property (!pin.warn |=> !warn_out) // RL11
        else $error("warning output without alarm");
    a_irq_level: assert property (|(stat & mask) |=> irq)
        else $error("interrupt missing");

    c_az_stop:   cover property (ev[EV_AZ]);
    c_peak_hold: cover property (ev[EV_PEAK] ##[1:20] is_peak && go);
    c_conv_done: cover property (done ##1 chan != $past(chan));
    c_wrap:      cover property (ev[EV_WRAP]);

endmodule
`default_nettype wire

// File: core/crth_pkg.sv
// Constants, types and register map of the ramp counter controller
// Functional notes
// [RL1] Eight-bit counter, counts up when gated
// [RL2] From zero, steps through 256 codes
// [RL3] Auto-zero stops counting at zero crossing
// [RL4] Auto-zero holds code; disabling clears it
// [RL5] Peak: reset pulse clears, count while above
// [RL6] Peak: ramp reaches input, counting stops
// [RL7] Peak: higher input resumes counting
// [RL8] Free conversion oscillator starts new conversions
// [RL9] Channel latch loads only on completion
// [RL10] Channel steps configurable, 64 typical, 256 max
// [RL11] First alarm drives 1 Hz square wave
// [RL12] Full-load alarm output steady, independent
// [RL13] Negative zero error flashes leading zero
// [RL14] Full counter wraps to zero, keeps counting
// [RL15] Counter run low holds counter cleared
// [RL16] Synchronised comparator, enable not gated clock
// [RL17] 1 Hz timing from programmable prescaler
package crth_pkg;

    // Timing
    localparam int CLK_HZ      = 100_000_000;
    localparam int FLASH_HZ    = 1;
    localparam int HALF_CYC    = CLK_HZ / (2 * FLASH_HZ);
    localparam int CONV_US     = 1000;
    localparam int CONV_CYC    = CONV_US * (CLK_HZ / 1_000_000);
    localparam int CHAN_TYP    = 64;
    localparam int CODES       = 256;
    localparam int SETTLE_CYC  = 8;     // Clocks to trust the comparator

    // Register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_MASK  = 8'h08;
    localparam logic [7:0] A_COUNT = 8'h0C;
    localparam logic [7:0] A_CHAN  = 8'h10;
    localparam logic [7:0] A_STEPS = 8'h14;
    localparam logic [7:0] A_PRE   = 8'h18;
    localparam logic [7:0] A_CONV  = 8'h1C;
    localparam logic [7:0] A_PINS  = 8'h20;

    // Control fields and reset value
    localparam int CTRL_W   = 5;
    localparam int CTRL_CLR = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h08;

    // Status event bits
    localparam int NEV     = 4;
    localparam int EV_AZ   = 0;
    localparam int EV_PEAK = 1;
    localparam int EV_DONE = 2;
    localparam int EV_WRAP = 3;

    localparam logic [7:0] CODE_MAX = 8'hFF;

    typedef enum logic [1:0] {
        M_AZ   = 2'b00,
        M_PEAK = 2'b01,
        M_CHAN = 2'b10,
        M_RAMP = 2'b11
    } crth_mode_e;

    typedef enum logic {
        C_IDLE = 1'b0,
        C_CONV = 1'b1
    } crth_cst_e;

    typedef struct packed {
        logic       clr;
        logic       run;
        logic       az_en;
        crth_mode_e mode;
    } crth_ctrl_s;

    typedef struct packed {
        logic zerr;
        logic full;
        logic warn;
        logic cmp;
    } crth_pins_s;

endpackage

// File: dv/crth_cmp_model.sv
// Comparator and DAC staircase model facing the ramp controller
`timescale 1ns/1ps
`default_nettype none
module crth_cmp_model (
    // Clock
    input  wire logic       clk,
    // Ramp code, analogue input level, response speed
    input  wire logic [7:0] dac_code,
    input  wire logic [7:0] level,
    input  wire logic       slow,
    // Comparator decision
    output logic            cmp_above
);
    logic [1:0] pipe = 2'b00;

    // DAC settles one clock; slow mode adds a second clock of lag
    always_ff @(posedge clk) begin
        pipe <= {pipe[0], level > dac_code};
    end

    // High while the input stands above the ramp
    assign cmp_above = slow ? pipe[1] : pipe[0];
endmodule
`default_nettype wire

// File: dv/crth_top_bench.sv
// Self-checking bench for the ramp counter controller
`timescale 1ns/1ps
`default_nettype none
module crth_top_bench import crth_pkg::*;;
    localparam int HC = 4;
    localparam int CC = 40;
    logic        clk = 0, reset = 1, hsel = 0, hwrite = 0, slow = 0;
    logic        warn_in = 0, full_in = 0, zero_err_in = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [7:0]  level = 0, dac_code, chan_out, c0;
    logic        cmp_above, hreadyout, hresp, warn_out, full_out;
    logic        flash_zero, irq;
    int          error_cnt = 0, checked = 0;

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    crth_top #(.HALF_CYCLES(HC), .CONV_CYCLES(CC), .CHAN_STEPS(64)) DUT (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cmp_above(cmp_above), .warn_in(warn_in),
        .full_in(full_in), .zero_err_in(zero_err_in), .dac_code(dac_code),
        .chan_out(chan_out), .warn_out(warn_out), .full_out(full_out),
        .flash_zero(flash_zero), .irq(irq));
    crth_cmp_model cmp_model (.clk(clk), .dac_code(dac_code),
        .level(level), .slow(slow), .cmp_above(cmp_above));

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("counts: checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Converter stops late by the synchroniser lag, so allow a window
    task automatic rng(input logic [7:0] v, input logic [7:0] lo);
        chk({31'h0, (v >= lo) && (v <= lo + 8'h8)}, 32'h1);
    endtask

    task automatic wait_rdy;
        @(posedge clk);
        for (int n = 0; hreadyout !== 1'b1; n++) begin
            if (n > 50) begin
                chk(32'h0, 32'h1);
                report_and_stop;
            end
            @(posedge clk);
        end
    endtask

    // One single word transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask

    task automatic wait_stat(input int b);
        for (int n = 0; n < 600; n++) begin
            bus(1'b0, A_STAT, 32'h0);
            if (rd[b] === 1'b1) return;
        end
        chk(32'h0, 32'h1);
        report_and_stop;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        bus(1'b0, A_CTRL, 32'h0);
        chk(rd, {27'h0, CTRL_RST});
        bus(1'b0, A_STEPS, 32'h0);
        chk(rd, 32'h3F);
        bus(1'b0, A_PRE, 32'h0);
        chk(rd, 32'(HC - 1));
        bus(1'b0, 8'h3C, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        chk({24'h0, dac_code}, 32'h0);
    endtask

    task automatic t_ramp;
        bus(1'b1, A_MASK, 32'h8);
        bus(1'b1, A_CTRL, 32'hB);
        repeat (3) @(posedge clk);
        #1 c0 = dac_code;
        // Step check across a full cycle, wrap included
        repeat (300) begin
            @(posedge clk);
            #1 chk({24'h0, dac_code}, {24'h0, 8'(c0 + 8'h1)});
            c0 = dac_code;
        end
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, A_CTRL, 32'h3);
        repeat (20) @(posedge clk);
        chk({24'h0, dac_code}, 32'h0);
        bus(1'b1, A_MASK, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, A_MASK, 32'h8);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, A_STAT, 32'hF);
        bus(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_az;
        level <= 8'h50;
        bus(1'b1, A_CTRL, 32'hC);
        wait_stat(EV_AZ);
        c0 = dac_code;
        rng(c0, 8'h50);
        level <= 8'hA0;
        repeat (150) @(posedge clk);
        chk({24'h0, dac_code}, {24'h0, c0});
        bus(1'b1, A_CTRL, 32'h8);
        repeat (5) @(posedge clk);
        chk({24'h0, dac_code}, 32'h0);
    endtask

    task automatic t_peak;
        slow <= 1'b1;
        level <= 8'h30;
        bus(1'b1, A_STAT, 32'hF);
        bus(1'b1, A_CTRL, 32'h19);
        wait_stat(EV_PEAK);
        repeat (10) @(posedge clk);
        c0 = dac_code;
        rng(c0, 8'h30);
        level <= 8'h10;
        repeat (60) @(posedge clk);
        chk({24'h0, dac_code}, {24'h0, c0});
        level <= 8'h70;
        repeat (150) @(posedge clk);
        rng(dac_code, 8'h70);
        level <= 8'h00;
        bus(1'b1, A_CTRL, 32'h19);
        repeat (4) @(posedge clk);
        chk({24'h0, dac_code}, 32'h0);
        slow <= 1'b0;
    endtask

    task automatic t_chan;
        logic moved;
        moved = 1'b0;
        level <= 8'h90;
        bus(1'b1, A_CONV, 32'd399);
        bus(1'b1, A_CTRL, 32'hA);
        bus(1'b1, A_STAT, 32'hF);
        wait_stat(EV_DONE);
        repeat (2) @(posedge clk);
        chk({24'h0, chan_out}, 32'h3F);
        // Latch must stay put while the next conversion ramps lower
        level <= 8'h20;
        repeat (350) begin
            @(posedge clk);
            if (chan_out !== 8'h3F) moved = 1'b1;
        end
        chk({31'h0, moved}, 32'h0);
        level <= 8'h90;
        bus(1'b1, A_STEPS, 32'hFF);
        bus(1'b1, A_STAT, 32'hF);
        wait_stat(EV_DONE);
        bus(1'b1, A_STAT, 32'hF);
        wait_stat(EV_DONE);
        repeat (2) @(posedge clk);
        rng(chan_out, 8'h90);
    endtask

    task automatic t_alarm;
        int hw, hf, hz, rw;
        logic pw;
        warn_in <= 1'b1;
        full_in <= 1'b1;
        zero_err_in <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            repeat (12) @(posedge clk);
            hw = 0;
            hf = 0;
            hz = 0;
            rw = 0;
            #1 pw = warn_out;
            repeat (40) begin
                @(posedge clk);
                #1 hw += warn_out;
                hf += full_out;
                hz += flash_zero;
                rw += (warn_out && !pw);
                pw = warn_out;
            end
            chk(hw, 20);
            chk(hf, 40);
            chk(hz, 20);
            chk(rw, p ? 2 : 5);
            bus(1'b1, A_PRE, 32'd9);
        end
        warn_in <= 1'b0;
        repeat (30) @(posedge clk);
        chk({30'h0, warn_out, full_out}, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset;
        t_ramp;
        t_az;
        t_peak;
        t_chan;
        t_alarm;
        report_and_stop;
    end
endmodule
`default_nettype wire
